// ---- logic/ioc_map.vh ----
// ioc_map.vh: offsets, field positions, reset values and sizes of the io cell register logic
// assumes: included by bare name from the io cell design files
`ifndef IOC_MAP_VH
`define IOC_MAP_VH

// register byte addresses on the wishbone slave
`define IOC_ADDR_CTRL      8'h00
`define IOC_ADDR_DELAY     8'h04
`define IOC_ADDR_STATUS    8'h08
`define IOC_ADDR_W         8

// control register fields
`define IOC_CTRL_CFG_DONE  0
`define IOC_CTRL_USED      1
`define IOC_CTRL_MODE_LO   2
`define IOC_CTRL_MODE_HI   3
`define IOC_CTRL_RX_REG    4
`define IOC_CTRL_RX_FALL   5
`define IOC_CTRL_TX_REG    6
`define IOC_CTRL_TX_FALL   7
`define IOC_CTRL_OE_FALL   8
`define IOC_CTRL_TX_INV    9
`define IOC_CTRL_DDR       10
`define IOC_CTRL_RESYNC    11
`define IOC_CTRL_SERDES    12
`define IOC_CTRL_PULL_DOWN 13
`define IOC_CTRL_W         14
`define IOC_CTRL_RESET     14'h0000
`define IOC_CTRL_FAST_MASK 14'h1000

// delay register fields
`define IOC_DLY_IN_LO      0
`define IOC_DLY_IN_HI      3
`define IOC_DLY_OUT_LO     4
`define IOC_DLY_OUT_HI     7
`define IOC_DLY_DYN_LO     8
`define IOC_DLY_DYN_HI     13
`define IOC_DLY_W          14
`define IOC_DLY_RESET      14'h0000
`define IOC_DLY_FAST_MASK  14'h3F00

// status register fields
`define IOC_STAT_PAD       0
`define IOC_STAT_DRIVE     1
`define IOC_STAT_FAST      2
`define IOC_STAT_RX_LO     4
`define IOC_STAT_RX_HI     7

// pad modes
`define IOC_MODE_INPUT     2'h0
`define IOC_MODE_OUTPUT    2'h1
`define IOC_MODE_BIDIR     2'h2
`define IOC_MODE_CLKOUT    2'h3

// delay chain and serializer sizes
`define IOC_TAP_W          6
`define IOC_TAP_MAX        6'h3F
`define IOC_CHAIN_DEPTH    64
`define IOC_SER_W          4
`define IOC_SER_CNT_W      2
`define IOC_SER_LAST       2'h3

`endif

// ---- logic/ioc_delay_chain.v ----
// ioc_delay_chain.v: tapped delay line, one bit wide, tap chosen at run time
// assumes: one clock with clock enable, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
`include "ioc_map.vh"

module ioc_delay_chain (
  // clock and reset
  input  wire                  i_clock,
  input  wire                  i_reset_n,
  input  wire                  i_clock_en,
  // data and tap
  input  wire                  i_data,
  input  wire [`IOC_TAP_W-1:0] i_tap,
  output reg                   o_data
);

  reg [`IOC_CHAIN_DEPTH-1:0] line_r;

  // stage 0 takes the input, each later stage takes the one before
  genvar g;
  generate
    for (g = 0; g < `IOC_CHAIN_DEPTH; g = g + 1) begin : g_stage
      if (g == 0) begin : g_first
        always @(posedge i_clock) begin
          if (!i_reset_n) begin
            line_r[g] <= 1'b0;
          end else if (i_clock_en) begin
            line_r[g] <= i_data;
          end
        end
      end else begin : g_next
        always @(posedge i_clock) begin
          if (!i_reset_n) begin
            line_r[g] <= 1'b0;
          end else if (i_clock_en) begin
            line_r[g] <= line_r[g-1];
          end
        end
      end
    end
  endgenerate

  // tap 0 gives the input one cycle late
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_data <= 1'b0;
    end else if (i_clock_en) begin
      if (i_tap == {`IOC_TAP_W{1'b0}}) begin
        o_data <= i_data;
      end else begin
        o_data <= line_r[i_tap - 6'h01];
      end
    end
  end

endmodule

`default_nettype wire

// ---- logic/ioc_cell.v ----
// ioc_cell.v: register logic of one general-purpose io cell, wishbone controlled
// assumes: input and output clocks arrive as levels synchronous to i_clock and are
// sampled, so their edges are seen one i_clock later; the pad buffer resolves the
// wire from o_pad_out and o_pad_oe_n
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ioc_map.vh"

// Function
// - input, output and output-enable registers exist
// - input mode: receive only, selectable edge
// - alternate input path is purely combinational
// - input dual edge samples both edges
// - output mode: transmit only, selectable edge
// - registered output may be inverted
// - output dual edge muxes two registers; code loads one register, tx_pad_r, on both out edges
// - bidirectional: in clock rx, out clock tx/oe
// - per-register edge; rx/tx registering independent
// - clock-output mode drives core clock out
// - during configuration pads weakly pulled up
// - unused pads tristated, pull-up or pull-down
// - dual edge on both paths, 2-bit words
// - normal dual edge: bit on its edge
// - resync dual edge: both bits on rise
// - resync input: fall bit delayed half cycle
// - 1:4 serdes only on fast pad, full-rate
// - dynamic delay fast only; static on both
// - rx bit 0 rise sample, bit 1 fall
// - deserializer first bit bit 0, last bit 3
module ioc_cell #(
  parameter FAST_PAD = 1
) (
  // clock, enable and reset
  input  wire        i_clock,
  input  wire        i_clock_en,
  input  wire        i_reset_n,
  // wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // core side clocks
  input  wire        i_in_clock,
  input  wire        i_out_clock,
  input  wire        i_clock_net,
  // core side data
  input  wire [3:0]  i_tx_data,
  input  wire        i_tx_oe,
  output reg  [3:0]  o_rx_data,
  output wire        o_alt,
  // pad buffer side
  input  wire        i_pad_in,
  output wire        o_pad_out,
  output reg         o_pad_oe_n,
  output reg         o_pull_up,
  output reg         o_pull_down
);

  reg  [`IOC_CTRL_W-1:0] ctrl_r;
  reg  [`IOC_DLY_W-1:0]  dly_r;
  reg                    in_clk_q_r;
  reg                    out_clk_q_r;
  reg                    rx_fall_hold_r;
  reg  [3:0]             rx_shift_r;
  reg  [1:0]             rx_cnt_r;
  reg                    tx_pad_r;
  reg                    tx_fall_hold_r;
  reg  [3:0]             tx_shift_r;
  reg  [1:0]             tx_cnt_r;
  reg                    oe_r;
  wire                   pad_dly;
  wire [`IOC_TAP_W-1:0]  in_tap;
  wire [`IOC_TAP_W-1:0]  out_tap;
  wire [`IOC_TAP_W:0]    in_sum;
  wire                   in_rise;
  wire                   in_fall;
  wire                   out_rise;
  wire                   out_fall;
  wire                   in_edge;
  wire                   out_edge;
  wire                   oe_edge;
  wire [1:0]             mode;
  wire                   cfg_done;
  wire                   used;
  wire                   rx_on;
  wire                   tx_on;
  wire                   ddr;
  wire                   resync;
  wire                   serdes;
  wire                   inv;
  wire                   wb_req;
  wire                   hit_ctrl;
  wire                   hit_dly;
  wire                   hit_stat;
  wire [31:0]            wmask;
  wire [`IOC_CTRL_W-1:0] ctrl_mask;
  wire [`IOC_DLY_W-1:0]  dly_mask;
  wire                   drive_on;

  // field decode
  assign cfg_done = ctrl_r[`IOC_CTRL_CFG_DONE];
  assign used     = ctrl_r[`IOC_CTRL_USED];
  assign mode     = ctrl_r[`IOC_CTRL_MODE_HI:`IOC_CTRL_MODE_LO];
  assign ddr      = ctrl_r[`IOC_CTRL_DDR];
  assign resync   = ctrl_r[`IOC_CTRL_RESYNC];
  assign serdes   = ctrl_r[`IOC_CTRL_SERDES] & !ddr;
  assign inv      = ctrl_r[`IOC_CTRL_TX_INV];
  assign rx_on    = cfg_done & used & ((mode == `IOC_MODE_INPUT) | (mode == `IOC_MODE_BIDIR));
  assign tx_on    = cfg_done & used & ((mode == `IOC_MODE_OUTPUT) | (mode == `IOC_MODE_BIDIR));

  // edges of the sampled core clocks
  assign in_rise  = i_in_clock & !in_clk_q_r;
  assign in_fall  = !i_in_clock & in_clk_q_r;
  assign out_rise = i_out_clock & !out_clk_q_r;
  assign out_fall = !i_out_clock & out_clk_q_r;
  assign in_edge  = ctrl_r[`IOC_CTRL_RX_FALL] ? in_fall : in_rise;
  assign out_edge = ctrl_r[`IOC_CTRL_TX_FALL] ? out_fall : out_rise;
  assign oe_edge  = ctrl_r[`IOC_CTRL_OE_FALL] ? out_fall : out_rise;

  // delay taps: static on both pad types, dynamic adds to the input tap only, on the fast pad only
  assign in_sum   = {1'b0, 2'h0, dly_r[`IOC_DLY_IN_HI:`IOC_DLY_IN_LO]}
                    + {1'b0, dly_r[`IOC_DLY_DYN_HI:`IOC_DLY_DYN_LO]};
  assign in_tap   = in_sum[`IOC_TAP_W] ? `IOC_TAP_MAX : in_sum[`IOC_TAP_W-1:0];
  assign out_tap  = {2'h0, dly_r[`IOC_DLY_OUT_HI:`IOC_DLY_OUT_LO]};

  // alternate path bypasses every register
  assign o_alt    = i_pad_in;

  ioc_delay_chain u_in_delay (
    .i_clock    (i_clock),
    .i_reset_n  (i_reset_n),
    .i_clock_en (i_clock_en),
    .i_data     (i_pad_in),
    .i_tap      (in_tap),
    .o_data     (pad_dly)
  );

  ioc_delay_chain u_out_delay (
    .i_clock    (i_clock),
    .i_reset_n  (i_reset_n),
    .i_clock_en (i_clock_en),
    .i_data     (tx_pad_r),
    .i_tap      (out_tap),
    .o_data     (o_pad_out)
  );

  // wishbone decode
  assign wb_req    = i_wb_cyc & i_wb_stb & !o_wb_ack;
  assign hit_ctrl  = i_wb_adr == `IOC_ADDR_CTRL;
  assign hit_dly   = i_wb_adr == `IOC_ADDR_DELAY;
  assign hit_stat  = i_wb_adr == `IOC_ADDR_STATUS;
  assign wmask     = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign ctrl_mask = (FAST_PAD != 0) ? {`IOC_CTRL_W{1'b1}} : ~`IOC_CTRL_FAST_MASK;
  assign dly_mask  = (FAST_PAD != 0) ? {`IOC_DLY_W{1'b1}} : ~`IOC_DLY_FAST_MASK;

  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      ctrl_r   <= `IOC_CTRL_RESET;
      dly_r    <= `IOC_DLY_RESET;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_clock_en) begin
      o_wb_ack <= wb_req;
      if (wb_req && i_wb_we && hit_ctrl) begin
        ctrl_r <= ((ctrl_r & ~wmask[`IOC_CTRL_W-1:0])
                  | (i_wb_dat[`IOC_CTRL_W-1:0] & wmask[`IOC_CTRL_W-1:0])) & ctrl_mask;
      end
      if (wb_req && i_wb_we && hit_dly) begin
        dly_r <= ((dly_r & ~wmask[`IOC_DLY_W-1:0])
                 | (i_wb_dat[`IOC_DLY_W-1:0] & wmask[`IOC_DLY_W-1:0])) & dly_mask;
      end
      if (wb_req && !i_wb_we) begin
        if (hit_ctrl) begin
          o_wb_dat <= {18'h00000, ctrl_r};
        end else if (hit_dly) begin
          o_wb_dat <= {18'h00000, dly_r};
        end else if (hit_stat) begin
          o_wb_dat <= {24'h000000, o_rx_data, 1'b0, (FAST_PAD != 0), !o_pad_oe_n, pad_dly};
        end else begin
          o_wb_dat <= 32'h0000_0000;
        end
      end else begin
        o_wb_dat <= 32'h0000_0000;
      end
    end
  end

  // clock samplers for edge detection
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      in_clk_q_r  <= 1'b0;
      out_clk_q_r <= 1'b0;
    end else if (i_clock_en) begin
      in_clk_q_r  <= i_in_clock;
      out_clk_q_r <= i_out_clock;
    end
  end

  // receive path: input capture register toward the core
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rx_data      <= 4'h0;
      rx_fall_hold_r <= 1'b0;
      rx_shift_r     <= 4'h0;
      rx_cnt_r       <= 2'h0;
    end else if (i_clock_en) begin
      if (!rx_on) begin
        o_rx_data <= 4'h0;
        rx_cnt_r  <= 2'h0;
      end else if (!ctrl_r[`IOC_CTRL_RX_REG]) begin
        o_rx_data <= {3'h0, pad_dly};
      end else if (ddr) begin
        if (resync) begin
          if (in_fall) begin
            rx_fall_hold_r <= pad_dly;
          end
          if (in_rise) begin
            o_rx_data <= {2'h0, rx_fall_hold_r, pad_dly};
          end
        end else begin
          if (in_rise) begin
            o_rx_data[0] <= pad_dly;
          end
          if (in_fall) begin
            o_rx_data[1] <= pad_dly;
          end
        end
      end else if (serdes) begin
        if (in_rise) begin
          rx_shift_r <= {pad_dly, rx_shift_r[3:1]};
          rx_cnt_r   <= rx_cnt_r + 2'h1;
          if (rx_cnt_r == `IOC_SER_LAST) begin
            o_rx_data <= {pad_dly, rx_shift_r[3:1]};
          end
        end
      end else if (in_edge) begin
        o_rx_data <= {3'h0, pad_dly};
      end
    end
  end

  // transmit path: output register toward the pad buffer
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      tx_pad_r       <= 1'b0;
      tx_fall_hold_r <= 1'b0;
      tx_shift_r     <= 4'h0;
      tx_cnt_r       <= 2'h0;
    end else if (i_clock_en) begin
      if (cfg_done && used && mode == `IOC_MODE_CLKOUT) begin
        tx_pad_r <= i_clock_net;
      end else if (!tx_on) begin
        tx_pad_r <= 1'b0;
        tx_cnt_r <= 2'h0;
      end else if (!ctrl_r[`IOC_CTRL_TX_REG]) begin
        tx_pad_r <= i_tx_data[0];
      end else if (ddr) begin
        if (resync) begin
          if (out_rise) begin
            tx_pad_r       <= i_tx_data[0] ^ inv;
            tx_fall_hold_r <= i_tx_data[1];
          end
          if (out_fall) begin
            tx_pad_r <= tx_fall_hold_r ^ inv;
          end
        end else begin
          if (out_rise) begin
            tx_pad_r <= i_tx_data[0] ^ inv;
          end
          if (out_fall) begin
            tx_pad_r <= i_tx_data[1] ^ inv;
          end
        end
      end else if (serdes) begin
        if (out_rise) begin
          tx_cnt_r <= tx_cnt_r + 2'h1;
          if (tx_cnt_r == 2'h0) begin
            tx_pad_r   <= i_tx_data[0] ^ inv;
            tx_shift_r <= {1'b0, i_tx_data[3:1]};
          end else begin
            tx_pad_r   <= tx_shift_r[0] ^ inv;
            tx_shift_r <= {1'b0, tx_shift_r[3:1]};
          end
        end
      end else if (out_edge) begin
        tx_pad_r <= i_tx_data[0] ^ inv;
      end
    end
  end

  // output-enable register, clocked from the output clock
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      oe_r <= 1'b0;
    end else if (i_clock_en) begin
      if (mode != `IOC_MODE_BIDIR || !used || !cfg_done) begin
        oe_r <= 1'b0;
      end else if (!ctrl_r[`IOC_CTRL_TX_REG]) begin
        oe_r <= i_tx_oe;
      end else if (oe_edge) begin
        oe_r <= i_tx_oe;
      end
    end
  end

  assign drive_on = cfg_done & used & ((mode == `IOC_MODE_OUTPUT) | (mode == `IOC_MODE_CLKOUT)
                    | ((mode == `IOC_MODE_BIDIR) & oe_r));

  // pad driver and default pulls
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_pad_oe_n  <= 1'b1;
      o_pull_up   <= 1'b1;
      o_pull_down <= 1'b0;
    end else if (i_clock_en) begin
      o_pad_oe_n <= !drive_on;
      if (!cfg_done) begin
        o_pull_up   <= 1'b1;
        o_pull_down <= 1'b0;
      end else if (!used) begin
        o_pull_up   <= !ctrl_r[`IOC_CTRL_PULL_DOWN];
        o_pull_down <= ctrl_r[`IOC_CTRL_PULL_DOWN];
      end else begin
        o_pull_up   <= 1'b0;
        o_pull_down <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- bench/ioc_cell_properties.sv ----
// ioc_cell_properties.sv: port-level assertions for the io cell
// assumes: bound into ioc_cell, single clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module ioc_cell_properties (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_clock_en,
  input wire logic        i_reset_n,
  // bus
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // core and pad
  input wire logic [3:0]  o_rx_data,
  input wire logic        o_alt,
  input wire logic        i_pad_in,
  input wire logic        o_pad_out,
  input wire logic        o_pad_oe_n,
  input wire logic        o_pull_up,
  input wire logic        o_pull_down
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack && i_clock_en;
  endsequence
  sequence s_pulled;
    (o_pull_up || o_pull_down) [*3];
  endsequence
  property p_reset;
    disable iff (1'b0)
    !i_reset_n && i_clock_en |=> o_pull_up && !o_pull_down && o_pad_oe_n && o_rx_data == 4'h0;
  endproperty
  chk_alt_direct: assert property (o_alt == i_pad_in)
    else $error("alt path differs from pad");
  chk_ack_next: assert property (s_take |=> o_wb_ack)
    else $error("bus request not answered next cycle");
  chk_ack_single: assert property (o_wb_ack && i_clock_en |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  chk_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data nonzero outside ack");
  chk_reset_state: assert property (p_reset)
    else $error("pad not weakly pulled up in reset");
  chk_pull_excl: assert property (!(o_pull_up && o_pull_down))
    else $error("both pulls active");
  chk_pull_drv: assert property (s_pulled |-> o_pad_oe_n)
    else $error("driver on while pad is pulled");
  chk_freeze_hold: assert property (!i_clock_en |=> $stable(o_rx_data) && $stable(o_pad_out))
    else $error("registers moved with clock enable low");
endmodule
bind ioc_cell ioc_cell_properties chk_i (.i_clock(i_clock), .i_clock_en(i_clock_en),
  .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_rx_data(o_rx_data), .o_alt(o_alt), .i_pad_in(i_pad_in),
  .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n), .o_pull_up(o_pull_up),
  .o_pull_down(o_pull_down));
`default_nettype wire

// ---- bench/ioc_pad_model.sv ----
// ioc_pad_model.sv: pad buffer with weak pulls and an external far-side driver
// assumes: cell outputs are levels, the bench supplies the external driver
`timescale 1ns/1ns
`default_nettype none
module ioc_pad_model (
  input  wire logic i_clock,
  input  wire logic i_pad_out,
  input  wire logic i_pad_oe_n,
  input  wire logic i_pull_up,
  input  wire logic i_pull_down,
  input  wire logic i_ext_en,
  input  wire logic i_ext_val,
  output logic      o_pad
);
  logic float_r = 1'b0;
  // an undriven unpulled pad wanders so a stale level never passes for data
  always @(posedge i_clock) float_r <= !float_r;
  always_comb begin
    if (!i_pad_oe_n) o_pad = i_pad_out;
    else if (i_ext_en) o_pad = i_ext_val;
    else if (i_pull_up) o_pad = 1'b1;
    else if (i_pull_down) o_pad = 1'b0;
    else o_pad = float_r;
  end
endmodule
`default_nettype wire

// ---- bench/test_io_cell_register_logic.sv ----
// test_io_cell_register_logic.sv: self-checking bench for the io cell register logic
// assumes: fast pad cell, pad model beside it, registers reached over wishbone
`timescale 1ns/1ns
`default_nettype none
`include "ioc_map.vh"
module test_io_cell_register_logic;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [31:0] m;} ioc_row_t;
  logic        i_clock = 1'b0;
  logic        en      = 1'b1;
  logic        rst_n   = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0;
  logic        in_clk  = 1'b0;
  logic        out_clk = 1'b0;
  logic        clk_net = 1'b0;
  logic [3:0]  tx      = 4'h0;
  logic        ext_en  = 1'b1;
  logic        ext_val = 1'b0;
  logic        oe      = 1'b0;
  logic [31:0] rd;
  int          n_fail  = 0;
  int          check_count = 0;
  wire  [31:0] wb_dat;
  wire  [3:0]  rx;
  wire         ack, pad, pad_out, oe_n, pu, pd;
  ioc_row_t    rows [4] = '{
    '{`IOC_ADDR_CTRL, 32'hFFFFFFFF, 32'h00003FFF, 32'hFFFFFFFF},
    '{`IOC_ADDR_DELAY, 32'hFFFFFFFF, 32'h00003FFF, 32'hFFFFFFFF},
    '{`IOC_ADDR_STATUS, 32'h0, 32'h00000004, 32'h00000004},
    '{8'h0C, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF}};
  ioc_cell #(.FAST_PAD(1)) uut (.i_clock(i_clock), .i_clock_en(en), .i_reset_n(rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(wb_dat), .o_wb_ack(ack), .i_in_clock(in_clk),
    .i_out_clock(out_clk), .i_clock_net(clk_net), .i_tx_data(tx), .i_tx_oe(oe),
    .o_rx_data(rx), .o_alt(), .i_pad_in(pad), .o_pad_out(pad_out), .o_pad_oe_n(oe_n),
    .o_pull_up(pu), .o_pull_down(pd));
  ioc_pad_model far (.i_clock(i_clock), .i_pad_out(pad_out), .i_pad_oe_n(oe_n),
    .i_pull_up(pu), .i_pull_down(pd), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_clock); while (ack !== 1'b1);
    r = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rd);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // core clocks are slow levels, held long enough for the cell's sampling latency
  task automatic inclk(input logic v);
    in_clk <= v;
    hold(5);
  endtask
  task automatic outclk(input logic v);
    out_clk <= v;
    hold(5);
  endtask
  task automatic ddr_in(input logic r, input logic f);
    ext_val <= r;
    hold(3);
    inclk(1'b1);
    ext_val <= f;
    hold(3);
    inclk(1'b0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clock);
    n_fail++;
    conclude();
  end
  initial begin
    hold(16);
    chk({24'h0, rx, pu, pd, oe_n, pad_out}, 32'h0A);
    rst_n <= 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      wb(1'b0, rows[i].a, 32'h0, rd);
      chk(rd & rows[i].m, rows[i].e);
      $display("row %0d done", i);
    end
    wr(`IOC_ADDR_DELAY, 32'h0);
    wr(`IOC_ADDR_CTRL, 32'h1);
    hold(2);
    chk({30'h0, pu, oe_n}, 32'h3);
    wr(`IOC_ADDR_CTRL, 32'h2001);
    hold(2);
    chk({30'h0, pd, pu}, 32'h2);
    ext_val <= 1'b1;
    wr(`IOC_ADDR_CTRL, 32'h13);
    inclk(1'b1);
    inclk(1'b0);
    chk({31'h0, rx[0]}, 32'h1);
    wr(`IOC_ADDR_CTRL, 32'h33);
    ext_val <= 1'b0;
    inclk(1'b1);
    chk({31'h0, rx[0]}, 32'h1);
    inclk(1'b0);
    chk({31'h0, rx[0]}, 32'h0);
    $display("input test done");
    wr(`IOC_ADDR_CTRL, 32'h413);
    ddr_in(1'b1, 1'b0);
    chk({30'h0, rx[1:0]}, 32'h1);
    wr(`IOC_ADDR_CTRL, 32'hC13);
    ddr_in(1'b0, 1'b1);
    ext_val <= 1'b0;
    hold(3);
    inclk(1'b1);
    chk({30'h0, rx[1:0]}, 32'h2);
    $display("dual edge input test done");
    ext_en <= 1'b0;
    tx <= 4'h1;
    wr(`IOC_ADDR_CTRL, 32'h47);
    outclk(1'b1);
    chk({30'h0, pad_out, oe_n}, 32'h2);
    chk({31'h0, pad}, 32'h1);
    wr(`IOC_ADDR_CTRL, 32'h247);
    outclk(1'b0);
    outclk(1'b1);
    chk({30'h0, pad_out, oe_n}, 32'h0);
    en <= 1'b0;
    tx <= 4'h0;
    outclk(1'b0);
    outclk(1'b1);
    chk({31'h0, pad_out}, 32'h0);
    en <= 1'b1;
    tx <= 4'h2;
    wr(`IOC_ADDR_CTRL, 32'h447);
    outclk(1'b0);
    outclk(1'b1);
    chk({31'h0, pad_out}, 32'h0);
    outclk(1'b0);
    chk({31'h0, pad_out}, 32'h1);
    $display("output test done");
    oe <= 1'b1;
    tx <= 4'h1;
    wr(`IOC_ADDR_CTRL, 32'h5B);
    outclk(1'b1);
    chk({30'h0, pad_out, oe_n}, 32'h2);
    oe <= 1'b0;
    outclk(1'b0);
    chk({31'h0, oe_n}, 32'h0);
    outclk(1'b1);
    chk({31'h0, oe_n}, 32'h1);
    $display("bidirectional test done");
    tx <= 4'hA;
    wr(`IOC_ADDR_CTRL, 32'h1047);
    outclk(1'b0);
    outclk(1'b1);
    chk({31'h0, pad_out}, 32'h0);
    outclk(1'b0);
    outclk(1'b1);
    chk({31'h0, pad_out}, 32'h1);
    $display("serializer test done");
    wr(`IOC_ADDR_CTRL, 32'hF);
    for (int v = 1; v >= 0; v--) begin
      clk_net <= v[0];
      hold(5);
      chk({31'h0, pad_out}, v);
    end
    $display("clock output test done");
    rst_n <= 1'b0;
    hold(2);
    chk({30'h0, pu, oe_n}, 32'h3);
    rst_n <= 1'b1;
    wb(1'b0, `IOC_ADDR_CTRL, 32'h0, rd);
    chk(rd, 32'h0);
    $display("second reset test done");
    conclude();
  end
endmodule
`default_nettype wire
